// ---- srcp_pkg.sv ----
// Shared constants and types for the serial register command port
package srcp_pkg;
    localparam int FRAME_BITS = 16;
    localparam int REG_COUNT = 8;
    // Register offsets
    localparam logic [3:0] OFS_DEVICE_STATUS_FLAGS = 4'h0;
    localparam logic [3:0] OFS_POWER_DOWN_CONFIG = 4'h1;
    localparam logic [3:0] OFS_SERIAL_PROTOCOL_CONFIG = 4'h2;
    localparam logic [3:0] OFS_OUTPUT_LANE_COUNT = 4'h3;
    localparam logic [3:0] OFS_STROBE_RETIMER_CONFIG = 4'h4;
    localparam logic [3:0] OFS_RESULT_WORD_FORMAT = 4'h5;
    localparam logic [3:0] OFS_AVERAGING_CONFIG = 4'h6;
    localparam logic [3:0] OFS_HALF_REFERENCE_OFFSET_SELECT = 4'h7;
    localparam logic [3:0] OFS_LAST = 4'h7;
    // Field positions in the protocol configuration register
    localparam int CLOCK_POLARITY_BIT_POS = 1;
    localparam int CLOCK_PHASE_BIT_POS = 0;
    // Values after reset
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [4:0] COUNT_RESET = 5'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Writable bits; reserved bits read as zero
    localparam logic [7:0] STATUS_STICKY_MASK = 8'h06;
    localparam logic [7:0] POWER_DOWN_MASK = 8'h2b;
    localparam logic [7:0] PROTOCOL_MASK = 8'h73;
    localparam logic [7:0] FULL_MASK = 8'hff;
    // Opcodes
    typedef enum logic [3:0] {
        OP_NO_OP_LOW_CODE = 4'h0,
        OP_WRITE = 4'h1,
        OP_READ = 4'h2,
        OP_SET_BITS = 4'h5,
        OP_CLEAR_BITS = 4'h6,
        OP_NO_OP_HIGH_CODE = 4'hf
    } srcp_opcode_t;
    typedef struct packed {
        logic [3:0] opcode;
        logic [3:0] addr;
        logic [7:0] data;
    } srcp_frame_t;
endpackage

// ---- srcp_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module srcp_sync
    import srcp_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1 <= RST_VALUE;
            sync_out <= RST_VALUE;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ---- srcp_top.sv ----
// Serial register command port: frame capture, decode and register file
// Notes on behaviour
// - Frames are accepted in all four clock polarity and phase modes.
// - After reset the port runs polarity 0, phase 0.
// - Bits captured on rising edges for phase 0, falling edges for phase 1.
// - Polarity and phase follow the fields of the protocol configuration register.
// - Opcodes 0000 and 1111 change no register.
// - Opcode 0001 writes the data field to the addressed register; in the status flags register, ones clear.
// - Opcode 0010 reads the addressed register; host sends 00h or FFh data.
// - Read data is shifted out during the following frame.
// - Opcode 0101 sets register bits where data bits are one, except in the status flags register.
// - Opcode 0110 clears register bits where data bits are one.
// - All other opcodes are no-operations.
// - Protocol register bit 1 is polarity, bit 0 phase, for reads and writes.
`timescale 1ns/1ps
module srcp_top
    import srcp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_in,
    input wire logic conversion_start_pin,
    input wire logic [1:0] status_event,
    output logic serial_out,
    output logic serial_out_oe,
    output logic [REG_COUNT-1:0][7:0] reg_file,
    output logic clock_polarity_bit,
    output logic clock_phase_bit
);
    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [3:0] pins_sync;
    logic sclk_s;
    logic cs_n_s;
    logic sdi_s;
    logic conversion_start_pin_s;
    logic sclk_d;
    logic cs_n_d;

    srcp_sync #(.WIDTH(4), .RST_VALUE(4'h4)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({conversion_start_pin, chip_select_n, serial_in, serial_clock}),
        .sync_out(pins_sync)
    );

    assign sclk_s = pins_sync[0];
    assign sdi_s = pins_sync[1];
    assign cs_n_s = pins_sync[2];
    assign conversion_start_pin_s = pins_sync[3];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    // ****************************************
    // Edge selection
    // ****************************************
    logic rise;
    logic fall;
    logic in_frame;
    logic cs_fall;
    logic cs_rise;
    logic capture_edge;
    logic launch_edge;

    assign rise = sclk_s & ~sclk_d;
    assign fall = ~sclk_s & sclk_d;
    assign in_frame = ~cs_n_s;
    assign cs_fall = ~cs_n_s & cs_n_d;
    assign cs_rise = cs_n_s & ~cs_n_d;
    // Capture edge follows phase alone; polarity only sets the idle level
    assign capture_edge = in_frame & (clock_phase_bit ? fall : rise);
    assign launch_edge = in_frame & (clock_phase_bit ? rise : fall);

    // ****************************************
    // Frame capture
    // ****************************************
    logic [15:0] rx_shift;
    logic [4:0] rx_count;
    srcp_frame_t frame;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_shift <= WORD_RESET;
            rx_count <= COUNT_RESET;
        end else if (cs_fall) begin
            rx_count <= COUNT_RESET;
        end else if (capture_edge) begin
            rx_shift <= {rx_shift[14:0], sdi_s};
            // Saturate so an over-long frame never aliases to 16
            if (rx_count != 5'h1f) begin
                rx_count <= rx_count + 5'h01;
            end
        end
    end

    assign frame = srcp_frame_t'(rx_shift);

    // ****************************************
    // Command decode
    // ****************************************
    logic execute;
    logic addr_ok;

    // Conversion start low marks a conversion frame, so no register op runs
    assign execute = cs_rise & (rx_count == 5'(FRAME_BITS)) & conversion_start_pin_s;
    assign addr_ok = frame.addr <= OFS_LAST;

    function automatic logic [7:0] write_mask(input logic [3:0] addr);
        if (addr == OFS_POWER_DOWN_CONFIG) begin
            write_mask = POWER_DOWN_MASK;
        end else if (addr == OFS_SERIAL_PROTOCOL_CONFIG) begin
            write_mask = PROTOCOL_MASK;
        end else begin
            write_mask = FULL_MASK;
        end
    endfunction

    // ****************************************
    // Register file
    // ****************************************
    genvar gi;
    generate
        for (gi = 1; gi < REG_COUNT; gi++) begin : g_cfg
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    reg_file[gi] <= REG_RESET;
                end else if (execute && addr_ok && frame.addr == 4'(gi)) begin
                    case (frame.opcode)
                        OP_WRITE: begin
                            reg_file[gi] <= frame.data & write_mask(4'(gi));
                        end
                        OP_SET_BITS: begin
                            reg_file[gi] <= (reg_file[gi] | frame.data) & write_mask(4'(gi));
                        end
                        OP_CLEAR_BITS: begin
                            reg_file[gi] <= reg_file[gi] & ~frame.data;
                        end
                        default: begin
                            reg_file[gi] <= reg_file[gi];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Status flags are sticky; a write of one clears, a new event wins
    logic [7:0] status_clear;

    always_comb begin
        status_clear = 8'h00;
        if (execute && frame.addr == OFS_DEVICE_STATUS_FLAGS) begin
            if (frame.opcode == OP_WRITE || frame.opcode == OP_CLEAR_BITS) begin
                status_clear = frame.data & STATUS_STICKY_MASK;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_file[0] <= REG_RESET;
        end else begin
            reg_file[0] <= ((reg_file[0] & ~status_clear) | {5'h00, status_event, 1'b0})
                & STATUS_STICKY_MASK;
        end
    end

    assign clock_polarity_bit = reg_file[OFS_SERIAL_PROTOCOL_CONFIG][CLOCK_POLARITY_BIT_POS];
    assign clock_phase_bit = reg_file[OFS_SERIAL_PROTOCOL_CONFIG][CLOCK_PHASE_BIT_POS];

    // ****************************************
    // Readback
    // ****************************************
    logic [15:0] tx_pending;
    logic [15:0] tx_shift;
    logic first_launch;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_pending <= WORD_RESET;
        end else if (execute) begin
            if (frame.opcode == OP_READ && addr_ok) begin
                tx_pending <= {reg_file[frame.addr[2:0]], 8'h00};
            end else begin
                tx_pending <= WORD_RESET;
            end
        end else if (cs_rise) begin
            tx_pending <= WORD_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_shift <= WORD_RESET;
            first_launch <= 1'b0;
        end else if (cs_fall) begin
            tx_shift <= tx_pending;
            first_launch <= clock_polarity_bit ^ clock_phase_bit;
        end else if (launch_edge) begin
            // When the first edge launches, the MSB already stands from chip select
            if (first_launch) begin
                first_launch <= 1'b0;
            end else begin
                tx_shift <= {tx_shift[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out <= cs_fall ? tx_pending[15] : tx_shift[15];
            serial_out_oe <= in_frame;
        end
    end
endmodule

// ---- srcp_props.sv ----
// Checker on the command port pins
`timescale 1ns/1ps
module srcp_props
    import srcp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_in,
    input wire logic conversion_start_pin,
    input wire logic [1:0] status_event,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic [REG_COUNT-1:0][7:0] reg_file,
    input wire logic clock_polarity_bit,
    input wire logic clock_phase_bit
);
    // ****
    // Properties
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Mode bits move only after a frame has ended, never inside one
    property p_pol;
        $changed(clock_polarity_bit) |-> chip_select_n && $past(chip_select_n, 3);
    endproperty
    property p_pha;
        $changed(clock_phase_bit) |-> chip_select_n && $past(chip_select_n, 3);
    endproperty
    property p_rst;
        $rose(rst_n) |-> reg_file == '0 && !clock_polarity_bit && !serial_out_oe;
    endproperty
    // Status bits excluded: events may set them at any time
    property p_hold;
        !chip_select_n [*8] |-> $stable(reg_file[7:1]);
    endproperty
    property p_idle;
        chip_select_n [*8] |-> $stable(reg_file[7:1]);
    endproperty
    property p_conv;
        !conversion_start_pin [*8] |-> $stable(reg_file[7:1]);
    endproperty
    property p_oe_off;
        chip_select_n [*6] |-> !serial_out_oe;
    endproperty
    property p_oe_on;
        !chip_select_n [*6] |-> serial_out_oe;
    endproperty
    property p_status;
        status_event[0] |-> ##[1:2] reg_file[0][1];
    endproperty
    a_pol: assert property (p_pol) else $error("polarity changed inside a frame");
    a_pha: assert property (p_pha) else $error("phase changed inside a frame");
    a_rst: assert property (p_rst) else $error("state after reset wrong");
    a_hold: assert property (p_hold) else $error("register moved in frame");
    a_idle: assert property (p_idle) else $error("register moved while idle");
    a_conv: assert property (p_conv) else $error("conversion frame executed");
    a_oe_off: assert property (p_oe_off) else $error("output driven while idle");
    a_oe_on: assert property (p_oe_on) else $error("output not driven in frame");
    a_status: assert property (p_status) else $error("status event lost");
    c_exec: cover property ($rose(chip_select_n));
    c_mode3: cover property (clock_polarity_bit && clock_phase_bit);
    c_clear: cover property ($fell(reg_file[0][1]));
endmodule

// ---- srcp_host.sv ----
// Host model: link master shifting command frames
`timescale 1ns/1ps
module srcp_host (
    input wire logic clock,
    input wire logic serial_out,
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_in,
    output logic conversion_start_pin
);
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    initial begin
        serial_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
        conversion_start_pin = 1'b1;
    end
    // ****
    // Frame shifting
    // ****
    task automatic half();
        repeat (5) @(posedge clock);
    endtask
    // Fewer than 16 bits only when a refusal is wanted
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rx);
        logic late;
        // Capture edge follows phase alone, so the second edge captures when they differ
        late = cpol ^ cpha;
        rx = 16'h0000;
        serial_clock <= cpol;
        half();
        chip_select_n <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            if (!late)
                serial_in <= w[i];
            half();
            serial_clock <= ~serial_clock;
            if (late)
                serial_in <= w[i];
            else
                rx[i] = serial_out;
            half();
            serial_clock <= ~serial_clock;
            if (late)
                rx[i] = serial_out;
        end
        half();
        chip_select_n <= 1'b1;
        // Released line must not keep the last bit
        serial_in <= ~serial_in;
        repeat (6) @(posedge clock);
    endtask
endmodule

// ---- tb_spi_register_command_port.sv ----
// Testbench of the serial register command port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_spi_register_command_port
    import srcp_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] status_event = 2'b00;
    logic serial_clock, chip_select_n, serial_in, conversion_start_pin;
    logic serial_out, serial_out_oe, clock_polarity_bit, clock_phase_bit;
    logic [REG_COUNT-1:0][7:0] reg_file;
    logic [15:0] rx;
    logic [7:0] v;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    srcp_top dut_u (
        .clock(clock),
        .rst_n(rst_n),
        .serial_clock(serial_clock),
        .chip_select_n(chip_select_n),
        .serial_in(serial_in),
        .conversion_start_pin(conversion_start_pin),
        .status_event(status_event),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .reg_file(reg_file),
        .clock_polarity_bit(clock_polarity_bit),
        .clock_phase_bit(clock_phase_bit)
    );
    srcp_host host_u (
        .clock(clock),
        .serial_out(serial_out),
        .serial_clock(serial_clock),
        .chip_select_n(chip_select_n),
        .serial_in(serial_in),
        .conversion_start_pin(conversion_start_pin)
    );
    initial forever #4 clock = ~clock;
    // ****
    // Run control
    // ****
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic cmd(input logic [3:0] op, input logic [3:0] a, input logic [7:0] d);
        host_u.frame({op, a, d}, 16, rx);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        for (int i = 0; i < REG_COUNT; i++)
            `CHK("reset reg", REG_RESET, reg_file[i])
        `CHK("reset mode", 2'b00, {clock_polarity_bit, clock_phase_bit})
        cmd(4'h1, OFS_POWER_DOWN_CONFIG, 8'hff);
        `CHK("write masked", POWER_DOWN_MASK, reg_file[1])
        cmd(4'h1, OFS_RESULT_WORD_FORMAT, 8'ha5);
        `CHK("write", 8'ha5, reg_file[5])
        cmd(4'h5, OFS_RESULT_WORD_FORMAT, 8'h5a);
        `CHK("set bits", 8'hff, reg_file[5])
        cmd(4'h6, OFS_RESULT_WORD_FORMAT, 8'h0f);
        `CHK("clear bits", 8'hf0, reg_file[5])
        for (int op = 0; op < 16; op++) begin
            if (op inside {1, 2, 5, 6})
                continue;
            cmd(op[3:0], OFS_RESULT_WORD_FORMAT, 8'h3c);
            `CHK("no-op", 8'hf0, reg_file[5])
        end
        host_u.frame(16'h1533, 15, rx);
        `CHK("short frame", 8'hf0, reg_file[5])
        host_u.conversion_start_pin <= 1'b0;
        cmd(4'h1, OFS_RESULT_WORD_FORMAT, 8'h11);
        `CHK("conv frame", 8'hf0, reg_file[5])
        host_u.conversion_start_pin <= 1'b1;
        cmd(4'h2, OFS_RESULT_WORD_FORMAT, 8'hff);
        `CHK("read frame out", 16'h0000, rx)
        cmd(4'h0, 4'h0, 8'h00);
        `CHK("readback", {8'hf0, 8'h00}, rx)
        status_event <= 2'b11;
        @(posedge clock);
        status_event <= 2'b00;
        @(posedge clock);
        `CHK("status set", STATUS_STICKY_MASK, reg_file[0])
        cmd(4'h6, OFS_DEVICE_STATUS_FLAGS, 8'h02);
        `CHK("status clear", 8'h04, reg_file[0])
        cmd(4'h1, OFS_DEVICE_STATUS_FLAGS, 8'h04);
        `CHK("status write clear", 8'h00, reg_file[0])
        // Mode 0 last, so the loop also returns to the reset mode
        for (int m = 1; m < 5; m++) begin
            v = 8'h30 + m[7:0];
            cmd(4'h1, OFS_SERIAL_PROTOCOL_CONFIG, {6'h00, m[1:0]});
            host_u.cpol = m[1];
            host_u.cpha = m[0];
            `CHK("mode", m[1:0], {clock_polarity_bit, clock_phase_bit})
            cmd(4'h1, OFS_AVERAGING_CONFIG, v);
            `CHK("mode write", v, reg_file[6])
            cmd(4'h2, OFS_AVERAGING_CONFIG, 8'h00);
            cmd(4'h0, 4'h0, 8'h00);
            `CHK("mode read", {v, 8'h00}, rx)
        end
        // Second reset from a non-default mode must bring back mode 0
        cmd(4'h1, OFS_SERIAL_PROTOCOL_CONFIG, 8'h03);
        `CHK("mode before reset", 2'b11, {clock_polarity_bit, clock_phase_bit})
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK("regs after reset", 64'h0, reg_file)
        `CHK("mode after reset", 2'b00, {clock_polarity_bit, clock_phase_bit})
        cmd(4'h1, OFS_AVERAGING_CONFIG, 8'h5c);
        `CHK("write after reset", 8'h5c, reg_file[6])
        complete_run();
    end
endmodule
bind srcp_top srcp_props chk_u (
    .clock(clock),
    .rst_n(rst_n),
    .serial_clock(serial_clock),
    .chip_select_n(chip_select_n),
    .serial_in(serial_in),
    .conversion_start_pin(conversion_start_pin),
    .status_event(status_event),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .reg_file(reg_file),
    .clock_polarity_bit(clock_polarity_bit),
    .clock_phase_bit(clock_phase_bit)
);
